/* File: cib_regs.svh */
// named constants for the processor identification bank: leaf numbers, word indices,
// field positions and the fixed words returned.
// assumes it is included by the package and the bank module and by nothing that redefines these names.
// Summary of operation
// - first data tlb 4k word: fully associative ffh high byte, 40 entries next byte
// - first instruction tlb 4k ways and entries read zero; second level carries them
// - first data cache word: 32 kb, 8-way, 1 line per tag, 64-byte line
// - first instruction cache word: 32 kb, 2-way, 1 line per tag, 64-byte line
// - second level 4k tlb word returns 4200h in upper half, the same as its lower half
// - second level ways nibble uses the coded table; 6h eight, ah 32, fh full
// - second level large page tlb word returns zero in all four fields
// - large page entry counts are in 2 mb entries; 4 mb uses two
// - second level 4k tlb word: ways code 4, 512 entries, data and instruction
// - second level cache word: 0200h kb, code 1000b 16-way, 1 line per tag, 64-byte
// - power word sets steady timestamp, hw perf state, 100 mhz steps, trip, sensor
// - linear width 30h with long mode else 20h; physical width 24h in bits 7:0
// - core count word: id bit count 1h; bits 7:0 hold cores minus one
// - virtualization revision 01h and 8h address space ids only when extension present
// - virtualization flags: pause filter, next ip save, lock, branch record, nested paging
// - both 1 gb page tlb words return zero in every field
// - performance hint word clears unaligned move and wide float flags
// - sampling capability word sets bits 7 down to 0
// - first level ways byte: 01h direct, 02h-feh literal ways, ffh fully associative
`ifndef CIB_REGS_SVH
`define CIB_REGS_SVH

// leaf numbers
`define CIB_LEAF_L1 32'h8000_0005
`define CIB_LEAF_L2 32'h8000_0006
`define CIB_LEAF_PWR 32'h8000_0007
`define CIB_LEAF_ADDR 32'h8000_0008
`define CIB_LEAF_VIRT 32'h8000_000a
`define CIB_LEAF_TLB1G 32'h8000_0019
`define CIB_LEAF_PERF 32'h8000_001a
`define CIB_LEAF_SAMP 32'h8000_001b
`define CIB_LEAF_RSVD9 32'h8000_0009
`define CIB_LEAF_GAP_LO 32'h8000_000b
`define CIB_LEAF_GAP_HI 32'h8000_0018

// word indices within a leaf
`define CIB_IDX_A 2'h0
`define CIB_IDX_B 2'h1
`define CIB_IDX_C 2'h2
`define CIB_IDX_D 2'h3

// first level ways codes and sizes
`define CIB_L1_WAYS_FULL 8'hff
`define CIB_L1_DTLB_ENTRIES 8'h28
`define CIB_L1_KB 8'h20
`define CIB_L1D_WAYS 8'h08
`define CIB_L1I_WAYS 8'h02
`define CIB_LINES_PER_TAG 8'h01
`define CIB_LINE_BYTES 8'h40

// second level ways codes and sizes
`define CIB_L2_CODE_4WAY 4'h4
`define CIB_L2_CODE_16WAY 4'h8
`define CIB_L2_TLB_ENTRIES 12'h200
`define CIB_L2_KB 16'h0200
`define CIB_L2_LINES_PER_TAG 4'h1

// power management bit positions
`define CIB_PWR_TS_BIT 0
`define CIB_PWR_TRIP_BIT 3
`define CIB_PWR_TM_BIT 4
`define CIB_PWR_STEP_BIT 6
`define CIB_PWR_HWPS_BIT 7
`define CIB_PWR_TSC_BIT 8

// address sizes
`define CIB_LIN_WIDTH_LONG 8'h30
`define CIB_LIN_WIDTH_LEGACY 8'h20
`define CIB_PHYS_WIDTH 8'h24
`define CIB_CORE_ID_BITS 4'h1

// virtualization
`define CIB_VIRT_REV 8'h01
`define CIB_VIRT_ASIDS 32'h0000_0008
`define CIB_VIRT_FLAGS 32'h0000_040f

// sampling
`define CIB_SAMP_FLAGS 8'hff

`endif

/* File: cib_pkg.sv */
// types shared by the processor identification bank.
// assumes cib_regs.svh is on the include path.
`include "cib_regs.svh"
package cib_pkg;

   // one identification request from the core
   typedef struct packed
   {
      logic valid;
      logic [31:0] leaf;
      logic [1:0] idx;
   } cib_req_t;

   // product straps, caught once after reset
   typedef struct packed
   {
      logic long_mode_flag;
      logic virtualization_extension;
      logic thermal_ctrl;
      logic [7:0] cores_minus_one;
   } cib_strap_t;

   // whole state of the bank
   typedef struct packed
   {
      logic captured;
      cib_strap_t strap;
      logic rsp_valid;
      logic [31:0] rsp_data;
   } cib_state_t;

endpackage

/* File: cib_bank.sv */
// read-only processor identification bank for the extended cache, tlb and feature leaves.
// assumes requests and straps come from logic on ref_clk_i; straps hold steady until the first edge after reset.
`include "cib_regs.svh"
module cib_bank
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // product straps
   input wire logic long_mode_flag_i,
   input wire logic virtualization_extension_i,
   input wire logic thermal_ctrl_i,
   input wire logic [7:0] cores_minus_one_i,
   // request from the core
   input wire cib_pkg::cib_req_t req_i,
   // answer
   output logic ready_o,
   output logic rsp_valid_o,
   output logic [31:0] rsp_data_o
);

   cib_pkg::cib_state_t state;
   cib_pkg::cib_state_t next_state;

   function automatic logic [31:0] lookup(input logic [31:0] leaf, input logic [1:0] idx,
                                          input cib_pkg::cib_strap_t s);
      logic [31:0] w;
      w = 32'h0000_0000; // reserved leaves and words read zero
      if (leaf == `CIB_LEAF_L1)
      begin
         if (idx == `CIB_IDX_B)
            // instruction half left zero, second level reports it
            w = {`CIB_L1_WAYS_FULL, `CIB_L1_DTLB_ENTRIES, 16'h0000};
         else if (idx == `CIB_IDX_C)
            w = {`CIB_L1_KB, `CIB_L1D_WAYS, `CIB_LINES_PER_TAG, `CIB_LINE_BYTES};
         else if (idx == `CIB_IDX_D)
            w = {`CIB_L1_KB, `CIB_L1I_WAYS, `CIB_LINES_PER_TAG, `CIB_LINE_BYTES};
      end
      else if (leaf == `CIB_LEAF_L2)
      begin
         // large page word stays zero; counts would be in 2 mb entries
         if (idx == `CIB_IDX_B)
            w = {`CIB_L2_CODE_4WAY, `CIB_L2_TLB_ENTRIES, `CIB_L2_CODE_4WAY, `CIB_L2_TLB_ENTRIES};
         else if (idx == `CIB_IDX_C)
            w = {`CIB_L2_KB, `CIB_L2_CODE_16WAY, `CIB_L2_LINES_PER_TAG, `CIB_LINE_BYTES};
      end
      else if (leaf == `CIB_LEAF_PWR)
      begin
         if (idx == `CIB_IDX_D)
         begin
            // limit, boost, voltage and frequency id bits stay clear
            w[`CIB_PWR_TSC_BIT] = 1'b1;
            w[`CIB_PWR_HWPS_BIT] = 1'b1;
            w[`CIB_PWR_STEP_BIT] = 1'b1;
            w[`CIB_PWR_TRIP_BIT] = 1'b1;
            w[`CIB_PWR_TS_BIT] = 1'b1;
            w[`CIB_PWR_TM_BIT] = s.thermal_ctrl;
         end
      end
      else if (leaf == `CIB_LEAF_ADDR)
      begin
         if (idx == `CIB_IDX_A)
            w = {16'h0000, s.long_mode_flag ? `CIB_LIN_WIDTH_LONG : `CIB_LIN_WIDTH_LEGACY,
                 `CIB_PHYS_WIDTH};
         else if (idx == `CIB_IDX_C)
            w = {16'h0000, `CIB_CORE_ID_BITS, 4'h0, s.cores_minus_one};
      end
      else if (leaf == `CIB_LEAF_VIRT)
      begin
         // without the extension every word of this leaf reads zero
         if (s.virtualization_extension)
         begin
            if (idx == `CIB_IDX_A)
               w = {24'h00_0000, `CIB_VIRT_REV};
            else if (idx == `CIB_IDX_B)
               w = `CIB_VIRT_ASIDS;
            else if (idx == `CIB_IDX_D)
               w = `CIB_VIRT_FLAGS;
         end
      end
      else if (leaf == `CIB_LEAF_SAMP)
      begin
         if (idx == `CIB_IDX_A)
            w = {24'h00_0000, `CIB_SAMP_FLAGS};
      end
      // 1 gb tlb and performance hint leaves fall through as zero
      return w;
   endfunction

   always_comb
   begin
      next_state = state;
      next_state.rsp_valid = 1'b0;
      // straps caught once, one cycle after release, then frozen
      if (!state.captured)
      begin
         next_state.captured = 1'b1;
         next_state.strap.long_mode_flag = long_mode_flag_i;
         next_state.strap.virtualization_extension = virtualization_extension_i;
         next_state.strap.thermal_ctrl = thermal_ctrl_i;
         next_state.strap.cores_minus_one = cores_minus_one_i;
      end
      else if (req_i.valid)
      begin
         next_state.rsp_valid = 1'b1;
         next_state.rsp_data = lookup(req_i.leaf, req_i.idx, state.strap);
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         state <= '0;
      else
         state <= next_state;
   end

   assign ready_o = state.captured;
   assign rsp_valid_o = state.rsp_valid;
   assign rsp_data_o = state.rsp_data;

   // checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_take(logic [31:0] lf, logic [1:0] ix);
      req_i.valid && ready_o && req_i.leaf == lf && req_i.idx == ix;
   endsequence

   sequence s_answer(logic [31:0] val);
      rsp_valid_o && rsp_data_o == val;
   endsequence

   sequence s_take_leaf(logic [31:0] lf);
      req_i.valid && ready_o && req_i.leaf == lf;
   endsequence

   sequence s_take_span(logic [31:0] lo, logic [31:0] hi);
      req_i.valid && ready_o && req_i.leaf >= lo && req_i.leaf <= hi;
   endsequence

   property p_l1_tlb;
      s_take(`CIB_LEAF_L1, `CIB_IDX_B) |=> s_answer(32'hff28_0000);
   endproperty
   a_l1_tlb: assert property (p_l1_tlb) else $error("l1 tlb word wrong");

   property p_l1_dcache;
      s_take(`CIB_LEAF_L1, `CIB_IDX_C) |=> s_answer(32'h2008_0140);
   endproperty
   a_l1_dcache: assert property (p_l1_dcache) else $error("l1 data cache word wrong");

   property p_l1_icache;
      s_take(`CIB_LEAF_L1, `CIB_IDX_D) |=> s_answer(32'h2002_0140);
   endproperty
   a_l1_icache: assert property (p_l1_icache) else $error("l1 instr cache word wrong");

   property p_l2_large;
      s_take(`CIB_LEAF_L2, `CIB_IDX_A) |=> s_answer(32'h0000_0000);
   endproperty
   a_l2_large: assert property (p_l2_large) else $error("l2 large page word not zero");

   property p_l2_tlb;
      s_take(`CIB_LEAF_L2, `CIB_IDX_B) |=> s_answer(32'h4200_4200);
   endproperty
   a_l2_tlb: assert property (p_l2_tlb) else $error("l2 4k tlb word wrong");

   property p_l2_cache;
      s_take(`CIB_LEAF_L2, `CIB_IDX_C) |=> s_answer(32'h0200_8140);
   endproperty
   a_l2_cache: assert property (p_l2_cache) else $error("l2 cache word wrong");

   property p_pwr;
      s_take(`CIB_LEAF_PWR, `CIB_IDX_D) |=> rsp_valid_o && (rsp_data_o & 32'hffff_ffef) == 32'h0000_01c9;
   endproperty
   a_pwr: assert property (p_pwr) else $error("power word wrong");

   property p_lin;
      s_take(`CIB_LEAF_ADDR, `CIB_IDX_A) |=>
         rsp_data_o == (state.strap.long_mode_flag ? 32'h0000_3024 : 32'h0000_2024);
   endproperty
   a_lin: assert property (p_lin) else $error("address size word wrong");

   property p_virt;
      s_take(`CIB_LEAF_VIRT, `CIB_IDX_D) |=>
         rsp_data_o == (state.strap.virtualization_extension ? 32'h0000_040f : 32'h0000_0000);
   endproperty
   a_virt: assert property (p_virt) else $error("virtualization flags wrong");

   property p_samp;
      s_take(`CIB_LEAF_SAMP, `CIB_IDX_A) |=> s_answer(32'h0000_00ff);
   endproperty
   a_samp: assert property (p_samp) else $error("sampling word wrong");

   property p_timing;
      (req_i.valid && ready_o) |=> rsp_valid_o ##1 (rsp_valid_o == $past(req_i.valid));
   endproperty
   a_timing: assert property (p_timing) else $error("answer not one cycle after request");

   property p_frozen;
      ready_o |=> ready_o && $stable(state.strap);
   endproperty
   a_frozen: assert property (p_frozen) else $error("straps changed after capture");

   // reserved and strap-dependent words inside the covered leaves
   property p_l1_a;
      s_take(`CIB_LEAF_L1, `CIB_IDX_A) |=> s_answer(32'h0000_0000);
   endproperty
   a_l1_a: assert property (p_l1_a) else $error("l1 word a not zero");

   property p_l2_d;
      s_take(`CIB_LEAF_L2, `CIB_IDX_D) |=> s_answer(32'h0000_0000);
   endproperty
   a_l2_d: assert property (p_l2_d) else $error("l2 word d not zero");

   property p_pwr_a;
      s_take(`CIB_LEAF_PWR, `CIB_IDX_A) |=> s_answer(32'h0000_0000);
   endproperty
   a_pwr_a: assert property (p_pwr_a) else $error("power word a not zero");

   property p_pwr_b;
      s_take(`CIB_LEAF_PWR, `CIB_IDX_B) |=> s_answer(32'h0000_0000);
   endproperty
   a_pwr_b: assert property (p_pwr_b) else $error("power word b not zero");

   property p_pwr_c;
      s_take(`CIB_LEAF_PWR, `CIB_IDX_C) |=> s_answer(32'h0000_0000);
   endproperty
   a_pwr_c: assert property (p_pwr_c) else $error("power word c not zero");

   property p_pwr_tm;
      s_take(`CIB_LEAF_PWR, `CIB_IDX_D) |=>
         s_answer(state.strap.thermal_ctrl ? 32'h0000_01d9 : 32'h0000_01c9);
   endproperty
   a_pwr_tm: assert property (p_pwr_tm) else $error("power word thermal bit wrong");

   property p_addr_b;
      s_take(`CIB_LEAF_ADDR, `CIB_IDX_B) |=> s_answer(32'h0000_0000);
   endproperty
   a_addr_b: assert property (p_addr_b) else $error("address word b not zero");

   property p_cores;
      s_take(`CIB_LEAF_ADDR, `CIB_IDX_C) |=> s_answer({24'h00_0010, state.strap.cores_minus_one});
   endproperty
   a_cores: assert property (p_cores) else $error("core count word wrong");

   property p_addr_d;
      s_take(`CIB_LEAF_ADDR, `CIB_IDX_D) |=> s_answer(32'h0000_0000);
   endproperty
   a_addr_d: assert property (p_addr_d) else $error("address word d not zero");

   property p_virt_rev;
      s_take(`CIB_LEAF_VIRT, `CIB_IDX_A) |=>
         s_answer(state.strap.virtualization_extension ? 32'h0000_0001 : 32'h0000_0000);
   endproperty
   a_virt_rev: assert property (p_virt_rev) else $error("virtualization revision wrong");

   property p_virt_asid;
      s_take(`CIB_LEAF_VIRT, `CIB_IDX_B) |=>
         s_answer(state.strap.virtualization_extension ? 32'h0000_0008 : 32'h0000_0000);
   endproperty
   a_virt_asid: assert property (p_virt_asid) else $error("address space id count wrong");

   property p_virt_c;
      s_take(`CIB_LEAF_VIRT, `CIB_IDX_C) |=> s_answer(32'h0000_0000);
   endproperty
   a_virt_c: assert property (p_virt_c) else $error("virtualization word c not zero");

   property p_1g_a;
      s_take(`CIB_LEAF_TLB1G, `CIB_IDX_A) |=> s_answer(32'h0000_0000);
   endproperty
   a_1g_a: assert property (p_1g_a) else $error("1 gb first level word not zero");

   property p_1g_b;
      s_take(`CIB_LEAF_TLB1G, `CIB_IDX_B) |=> s_answer(32'h0000_0000);
   endproperty
   a_1g_b: assert property (p_1g_b) else $error("1 gb second level word not zero");

   property p_1g_c;
      s_take(`CIB_LEAF_TLB1G, `CIB_IDX_C) |=> s_answer(32'h0000_0000);
   endproperty
   a_1g_c: assert property (p_1g_c) else $error("1 gb word c not zero");

   property p_1g_d;
      s_take(`CIB_LEAF_TLB1G, `CIB_IDX_D) |=> s_answer(32'h0000_0000);
   endproperty
   a_1g_d: assert property (p_1g_d) else $error("1 gb word d not zero");

   property p_perf_a;
      s_take(`CIB_LEAF_PERF, `CIB_IDX_A) |=> s_answer(32'h0000_0000);
   endproperty
   a_perf_a: assert property (p_perf_a) else $error("performance hint word not zero");

   property p_perf_b;
      s_take(`CIB_LEAF_PERF, `CIB_IDX_B) |=> s_answer(32'h0000_0000);
   endproperty
   a_perf_b: assert property (p_perf_b) else $error("performance word b not zero");

   property p_perf_c;
      s_take(`CIB_LEAF_PERF, `CIB_IDX_C) |=> s_answer(32'h0000_0000);
   endproperty
   a_perf_c: assert property (p_perf_c) else $error("performance word c not zero");

   property p_perf_d;
      s_take(`CIB_LEAF_PERF, `CIB_IDX_D) |=> s_answer(32'h0000_0000);
   endproperty
   a_perf_d: assert property (p_perf_d) else $error("performance word d not zero");

   property p_samp_b;
      s_take(`CIB_LEAF_SAMP, `CIB_IDX_B) |=> s_answer(32'h0000_0000);
   endproperty
   a_samp_b: assert property (p_samp_b) else $error("sampling word b not zero");

   property p_samp_c;
      s_take(`CIB_LEAF_SAMP, `CIB_IDX_C) |=> s_answer(32'h0000_0000);
   endproperty
   a_samp_c: assert property (p_samp_c) else $error("sampling word c not zero");

   property p_samp_d;
      s_take(`CIB_LEAF_SAMP, `CIB_IDX_D) |=> s_answer(32'h0000_0000);
   endproperty
   a_samp_d: assert property (p_samp_d) else $error("sampling word d not zero");

   // reserved and unknown leaves answer zero so software probing past the top leaf stays harmless
   property p_leaf_nine;
      s_take_leaf(`CIB_LEAF_RSVD9) |=> s_answer(32'h0000_0000);
   endproperty
   a_leaf_nine: assert property (p_leaf_nine) else $error("reserved leaf nine not zero");

   property p_leaf_gap;
      s_take_span(`CIB_LEAF_GAP_LO, `CIB_LEAF_GAP_HI) |=> s_answer(32'h0000_0000);
   endproperty
   a_leaf_gap: assert property (p_leaf_gap) else $error("reserved leaf range not zero");

   property p_leaf_out;
      (req_i.valid && ready_o && (req_i.leaf < `CIB_LEAF_L1 || req_i.leaf > `CIB_LEAF_SAMP)) |=>
         s_answer(32'h0000_0000);
   endproperty
   a_leaf_out: assert property (p_leaf_out) else $error("uncovered leaf not zero");

   // straps and reset
   property p_reset_clear;
      disable iff (1'b0)
      rst_i |=> !ready_o && !rsp_valid_o && rsp_data_o == 32'h0000_0000;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");

   property p_capture;
      !ready_o |=>
         ready_o &&
         state.strap == $past({long_mode_flag_i, virtualization_extension_i, thermal_ctrl_i, cores_minus_one_i});
   endproperty
   a_capture: assert property (p_capture) else $error("straps not caught at first edge");

   // answer timing
   property p_refused;
      !ready_o |=> !rsp_valid_o;
   endproperty
   a_refused: assert property (p_refused) else $error("answer to a request made before ready");

   property p_no_spurious;
      !req_i.valid |=> !rsp_valid_o;
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("answer without a request");

   property p_hold;
      !(req_i.valid && ready_o) |=> $stable(rsp_data_o);
   endproperty
   a_hold: assert property (p_hold) else $error("answer word moved without a request");

   property p_back_to_back;
      s_take(`CIB_LEAF_L1, `CIB_IDX_C) ##1 s_take(`CIB_LEAF_L2, `CIB_IDX_C) |->
         s_answer(32'h2008_0140) ##1 s_answer(32'h0200_8140);
   endproperty
   a_back_to_back: assert property (p_back_to_back) else $error("back to back answers out of order");

endmodule

/* File: cpu_ident_cache_tlb_leaves_tb.sv */
// self-checking bench for the processor identification bank.
// assumes cib_pkg and cib_bank are compiled first and cib_regs.svh is on the include path.
`include "cib_regs.svh"
`define CHK(a, e) cmp(32'(a), 32'(e))
module cpu_ident_cache_tlb_leaves_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   cib_pkg::cib_strap_t strap = '0;
   cib_pkg::cib_req_t req = '0;
   logic ready;
   logic rsp_valid;
   logic [31:0] rsp_data;
   int failures = 0;
   int checked = 0;

   always #5 ref_clk = ~ref_clk;

   cib_bank dut_u
   (
      .ref_clk_i(ref_clk),
      .rst_i(rst),
      .long_mode_flag_i(strap.long_mode_flag),
      .virtualization_extension_i(strap.virtualization_extension),
      .thermal_ctrl_i(strap.thermal_ctrl),
      .cores_minus_one_i(strap.cores_minus_one),
      .req_i(req),
      .ready_o(ready),
      .rsp_valid_o(rsp_valid),
      .rsp_data_o(rsp_data)
   );

   task cmp(input logic [31:0] a, input logic [31:0] e);
      checked++;
      if (a !== e)
      begin
         failures++;
         $display("mismatch %0t got %h want %h", $time, a, e);
      end
   endtask

   task complete_run;
      if (failures == 0 && checked > 0)
      begin
         $display("Result: passed");
      end
      else
      begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // a request held through reset must be dropped, not answered late
   task do_reset(input cib_pkg::cib_strap_t s);
      @(posedge ref_clk);
      rst <= 1'b1;
      strap <= s;
      req <= {1'b1, `CIB_LEAF_L1, 2'h1};
      repeat (5) @(posedge ref_clk);
      #1 `CHK(ready, 1'b0);
      @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      req.valid <= 1'b0;
      #1 `CHK(ready, 1'b1);
      `CHK(rsp_valid, 1'b0);
   endtask

   // one request; answer one cycle later, then a one-cycle pulse with data held
   task ask(input logic [31:0] lf, input logic [1:0] ix, input logic [31:0] ex);
      @(posedge ref_clk);
      req <= {1'b1, lf, ix};
      @(posedge ref_clk);
      req.valid <= 1'b0;
      #1 `CHK(rsp_valid, 1'b1);
      `CHK(rsp_data, ex);
      @(posedge ref_clk);
      #1 `CHK(rsp_valid, 1'b0);
      `CHK(rsp_data, ex);
   endtask

   task scen_first_level;
      ask(`CIB_LEAF_L1, 2'h1, 32'hff28_0000);
      ask(`CIB_LEAF_L1, 2'h2, 32'h2008_0140);
      ask(`CIB_LEAF_L1, 2'h3, 32'h2002_0140);
   endtask

   task scen_second_level;
      ask(`CIB_LEAF_L2, 2'h0, 32'h0);
      ask(`CIB_LEAF_L2, 2'h1, 32'h4200_4200);
      ask(`CIB_LEAF_L2, 2'h2, 32'h0200_8140);
      ask(`CIB_LEAF_L2, 2'h3, 32'h0);
   endtask

   // expectations follow the straps caught at reset, not the live pins
   task scen_straps(input cib_pkg::cib_strap_t s);
      ask(`CIB_LEAF_PWR, 2'h3, 32'h0000_01c9 | {27'h0, s.thermal_ctrl, 4'h0});
      ask(`CIB_LEAF_PWR, 2'h0, 32'h0);
      ask(`CIB_LEAF_ADDR, 2'h0, {16'h0, s.long_mode_flag ? 8'h30 : 8'h20, 8'h24});
      ask(`CIB_LEAF_ADDR, 2'h2, {24'h00_0010, s.cores_minus_one});
      ask(`CIB_LEAF_ADDR, 2'h3, 32'h0);
      ask(`CIB_LEAF_VIRT, 2'h0, s.virtualization_extension ? 32'h1 : 32'h0);
      ask(`CIB_LEAF_VIRT, 2'h1, s.virtualization_extension ? 32'h8 : 32'h0);
      ask(`CIB_LEAF_VIRT, 2'h2, 32'h0);
      ask(`CIB_LEAF_VIRT, 2'h3, s.virtualization_extension ? 32'h40f : 32'h0);
   endtask

   task scen_tail_leaves;
      ask(`CIB_LEAF_TLB1G, 2'h0, 32'h0);
      ask(`CIB_LEAF_TLB1G, 2'h1, 32'h0);
      ask(`CIB_LEAF_PERF, 2'h0, 32'h0);
      ask(`CIB_LEAF_SAMP, 2'h0, 32'h0000_00ff);
      ask(`CIB_LEAF_SAMP, 2'h1, 32'h0);
      ask(32'h8000_0009, 2'h0, 32'h0);
      ask(32'h8000_000b, 2'h1, 32'h0);
      ask(32'h8000_0018, 2'h3, 32'h0);
      ask(`CIB_LEAF_L1, 2'h0, 32'h0);
      ask(`CIB_LEAF_PWR, 2'h1, 32'h0);
      ask(`CIB_LEAF_PWR, 2'h2, 32'h0);
      ask(`CIB_LEAF_ADDR, 2'h1, 32'h0);
      ask(`CIB_LEAF_TLB1G, 2'h2, 32'h0);
      ask(`CIB_LEAF_TLB1G, 2'h3, 32'h0);
      ask(`CIB_LEAF_PERF, 2'h1, 32'h0);
      ask(`CIB_LEAF_PERF, 2'h2, 32'h0);
      ask(`CIB_LEAF_PERF, 2'h3, 32'h0);
      ask(`CIB_LEAF_SAMP, 2'h2, 32'h0);
      ask(`CIB_LEAF_SAMP, 2'h3, 32'h0);
      ask(32'h8000_001c, 2'h0, 32'h0);
      ask(32'h0000_0000, 2'h0, 32'h0);
   endtask

   // requests on consecutive cycles must each get their own answer in order
   task scen_back_to_back;
      @(posedge ref_clk);
      req <= {1'b1, `CIB_LEAF_L1, 2'h2};
      @(posedge ref_clk);
      req <= {1'b1, `CIB_LEAF_L2, 2'h2};
      #1 `CHK(rsp_data, 32'h2008_0140);
      @(posedge ref_clk);
      req <= {1'b1, `CIB_LEAF_SAMP, 2'h0};
      #1 `CHK(rsp_data, 32'h0200_8140);
      @(posedge ref_clk);
      req.valid <= 1'b0;
      #1 `CHK(rsp_data, 32'h0000_00ff);
      `CHK(rsp_valid, 1'b1);
   endtask

   // flipping the strap pins after reset must not move any word
   task scen_frozen(input cib_pkg::cib_strap_t s);
      @(posedge ref_clk);
      strap <= ~s;
      scen_straps(s);
   endtask

   initial
   begin
      do_reset('{1'b1, 1'b1, 1'b1, 8'h01});
      scen_first_level();
      scen_second_level();
      scen_straps('{1'b1, 1'b1, 1'b1, 8'h01});
      scen_tail_leaves();
      scen_back_to_back();
      do_reset('{1'b0, 1'b0, 1'b0, 8'h00});
      scen_frozen('{1'b0, 1'b0, 1'b0, 8'h00});
      complete_run();
   end
endmodule
